// ==== dsef_params.svh ====
/*
 Constants for the drive security erase and freeze-lock block.
 Assumes inclusion by the package and by the design module.
*/
`ifndef DSEF_PARAMS_SVH
`define DSEF_PARAMS_SVH
`define DSEF_OP_SET_PW 8'hf1
`define DSEF_OP_UNLOCK 8'hf2
`define DSEF_OP_PREPARE 8'hf3
`define DSEF_OP_ERASE 8'hf4
`define DSEF_OP_FREEZE 8'hf5
`define DSEF_OP_DISABLE 8'hf6
`define DSEF_CW_IDENT_BIT 0
`define DSEF_CW_ENH_BIT 1
`define DSEF_PW_FIRST_WORD 8'h01
`define DSEF_PW_LAST_WORD 8'h10
`define DSEF_SECTOR_LAST_WORD 8'hff
`define DSEF_ERR_ABT_BIT 2
`define DSEF_ERR_IDN_BIT 4
`define DSEF_ST_BSY_BIT 7
`define DSEF_ST_RDY_BIT 6
`define DSEF_ST_DF_BIT 5
`define DSEF_ST_DSC_BIT 4
`define DSEF_ST_DRQ_BIT 3
`define DSEF_ST_ERR_BIT 0
`define DSEF_ERASE_START_LBA 48'h0
`define DSEF_ID_ERASE_TIME_WORD 8'h59
`define DSEF_ERASE_TIME_RST 16'h0001
`endif

// ==== dsef_pkg.sv ====
/*
 Types for the drive security erase and freeze-lock block.
 Assumes the constant header is on the include path.
*/
`include "dsef_params.svh"
package dsef_pkg;
    typedef struct packed {
        logic [7:0] opcode;
        logic valid;
    } dsef_cmd_t;
    typedef struct packed {
        logic [15:0] data;
        logic valid;
    } dsef_word_t;
    typedef struct packed {
        logic [47:0] lba;
        logic valid;
    } dsef_wr_t;
    typedef enum logic [4:0] {
        DSEF_IDLE = 5'b00001,
        DSEF_XFER = 5'b00010,
        DSEF_CHECK = 5'b00100,
        DSEF_ERASE = 5'b01000,
        DSEF_DONE = 5'b10000
    } dsef_state_t;
endpackage : dsef_pkg

// ==== dsef_core.sv ====
/*
 Security erase-unit and freeze-lock command handling of a drive.
 Assumes commands and data words synchronous to core_clk_in, and a media
 writer that accepts one zero-fill block write per cycle when ready.
*/
// Function
// - Opcode f4 selects erase; completion clears busy and fault, only abort/IDN errors.
// - Erase all user sectors first, then turn off the lock function.
// - Erase from block 0 to native maximum, ignoring host maximum limits.
// - Erase requests exactly one data sector from the host.
// - Security disabled with user identifier aborts the erase.
// - Password mismatch aborts with no erase.
// - Control bit 0: 0 compares user password, 1 master password.
// - Control bit 1 is enhanced mode, unsupported; bits 2 to 15 reserved.
// - Sector: word 0 control, words 1 to 16 password, rest reserved.
// - Erase writes zeros with no read-back check.
// - Defect and reassign lists stay untouched by erase.
// - Erase without directly preceding prepare is aborted.
// - Master password remains stored after the erase.
// - Lock disabled: no password compare, erase directly.
// - Erase time reported in identify word 89.
// - Opcode f5 freezes at once, no data, abort only error.
// - Frozen rejects set-password, unlock, disable-password and erase.
// - Frozen clears only at power-off.
`timescale 1ns/1ns
`include "dsef_params.svh"
module dsef_core #(
    parameter int LBA_W = 48,
    parameter int PW_WORDS = 16
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic por_nrst_in,
    input dsef_pkg::dsef_cmd_t cmd_in,
    input dsef_pkg::dsef_word_t wdata_in,
    input wire logic [LBA_W-1:0] native_max_lba_in,
    input wire logic [PW_WORDS*16-1:0] user_pw_in,
    input wire logic [PW_WORDS*16-1:0] master_pw_in,
    input wire logic sec_enabled_in,
    input wire logic media_ready_in,
    input wire logic [7:0] id_word_sel_in,
    output dsef_pkg::dsef_wr_t media_wr_out,
    output logic [15:0] media_wdata_out,
    output logic lock_off_out,
    output logic frozen_out,
    output logic cmd_done_out,
    output logic [7:0] status_out,
    output logic [7:0] error_out,
    output logic [15:0] id_word_out
);
    import dsef_pkg::*;

    dsef_state_t state_ff;
    dsef_state_t nxt_state;
    logic [7:0] wcnt_ff;
    logic [15:0] ctrl_ff;
    logic [PW_WORDS*16-1:0] pw_ff;
    logic prep_ff;
    logic frozen_ff;
    logic [LBA_W-1:0] lba_ff;
    logic [LBA_W-1:0] max_ff;
    logic abort_ff;
    logic done_ff;
    logic lock_off_ff;
    logic [7:0] status_ff;
    logic [7:0] error_ff;
    logic [15:0] id_ff;
    logic pw_ok;
    logic id_user;
    logic lock_cmd;
    logic reject_now;
    logic erase_ok;
    logic last_word;
    logic erase_last;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    assign id_user = ~ctrl_ff[`DSEF_CW_IDENT_BIT];
    assign pw_ok = id_user ? (pw_ff == user_pw_in) : (pw_ff == master_pw_in);
    assign lock_cmd = (cmd_in.opcode == `DSEF_OP_SET_PW) ||
        (cmd_in.opcode == `DSEF_OP_UNLOCK) || (cmd_in.opcode == `DSEF_OP_DISABLE) ||
        (cmd_in.opcode == `DSEF_OP_ERASE);
    assign reject_now = cmd_in.valid && lock_cmd && (frozen_ff ||
        ((cmd_in.opcode == `DSEF_OP_ERASE) && !prep_ff));
    // Password compare skipped when lock disabled, user id aborts then
    assign erase_ok = sec_enabled_in ? pw_ok : !id_user;
    assign last_word = (wcnt_ff == `DSEF_SECTOR_LAST_WORD);
    assign erase_last = media_ready_in && (lba_ff == max_ff);

    ////////////////////////////////////////////////////////////////////////
    // State machine
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            DSEF_IDLE: begin
                if (cmd_in.valid && (cmd_in.opcode == `DSEF_OP_ERASE) && !reject_now) begin
                    nxt_state = DSEF_XFER;
                end
            end
            DSEF_XFER: begin
                if (wdata_in.valid && last_word) begin
                    nxt_state = DSEF_CHECK;
                end
            end
            DSEF_CHECK: begin
                nxt_state = erase_ok ? DSEF_ERASE : DSEF_DONE;
            end
            DSEF_ERASE: begin
                if (erase_last) begin
                    nxt_state = DSEF_DONE;
                end
            end
            DSEF_DONE: begin
                nxt_state = DSEF_IDLE;
            end
            default: begin
                nxt_state = DSEF_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= DSEF_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sector capture
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wcnt_ff <= 8'h00;
            ctrl_ff <= 16'h0000;
            pw_ff <= '0;
        end else if (state_ff == DSEF_IDLE) begin
            wcnt_ff <= 8'h00;
        end else if ((state_ff == DSEF_XFER) && wdata_in.valid) begin
            wcnt_ff <= wcnt_ff + 8'h01;
            if (wcnt_ff == 8'h00) begin
                ctrl_ff <= wdata_in.data;
            end
            if ((wcnt_ff >= `DSEF_PW_FIRST_WORD) && (wcnt_ff <= `DSEF_PW_LAST_WORD)) begin
                pw_ff <= {wdata_in.data, pw_ff[PW_WORDS*16-1:16]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prepare tracking: only the command right before erase counts
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prep_ff <= 1'b0;
        end else if (cmd_in.valid) begin
            prep_ff <= (cmd_in.opcode == `DSEF_OP_PREPARE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frozen mode, cleared by power-on reset only
    always_ff @(posedge core_clk_in or negedge por_nrst_in) begin
        if (!por_nrst_in) begin
            frozen_ff <= 1'b0;
        end else if (cmd_in.valid && (cmd_in.opcode == `DSEF_OP_FREEZE)) begin
            frozen_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Media wipe, zeros only, no verify, defect lists untouched
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lba_ff <= '0;
            max_ff <= '0;
        end else if (state_ff == DSEF_CHECK) begin
            lba_ff <= LBA_W'(`DSEF_ERASE_START_LBA);
            max_ff <= native_max_lba_in;
        end else if ((state_ff == DSEF_ERASE) && media_ready_in && !erase_last) begin
            lba_ff <= lba_ff + {{(LBA_W-1){1'b0}}, 1'b1};
        end
    end

    assign media_wr_out = '{lba: 48'(lba_ff), valid: (state_ff == DSEF_ERASE)};
    assign media_wdata_out = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Lock function off after the wipe; master password untouched
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lock_off_ff <= 1'b0;
        end else begin
            lock_off_ff <= (state_ff == DSEF_ERASE) && erase_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion, status and error
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            abort_ff <= 1'b0;
        end else if ((state_ff == DSEF_CHECK) && !erase_ok) begin
            abort_ff <= 1'b1;
        end else if (state_ff == DSEF_IDLE) begin
            abort_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_ff <= 1'b0;
            status_ff <= 8'h50;
            error_ff <= 8'h00;
        end else begin
            done_ff <= reject_now || (state_ff == DSEF_DONE) ||
                (cmd_in.valid && (state_ff == DSEF_IDLE) &&
                ((cmd_in.opcode == `DSEF_OP_FREEZE) || (cmd_in.opcode == `DSEF_OP_PREPARE)));
            if (reject_now || ((state_ff == DSEF_DONE) && abort_ff)) begin
                status_ff <= 8'h51;
                error_ff <= 8'h04;
            end else if ((state_ff == DSEF_DONE) || (cmd_in.valid && (state_ff == DSEF_IDLE))) begin
                status_ff <= 8'h50;
                error_ff <= 8'h00;
            end else if (nxt_state == DSEF_XFER) begin
                status_ff <= 8'h58;
            end else if (state_ff == DSEF_CHECK) begin
                status_ff <= 8'h80;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Identify word for erase time
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            id_ff <= 16'h0000;
        end else begin
            id_ff <= (id_word_sel_in == `DSEF_ID_ERASE_TIME_WORD) ?
                `DSEF_ERASE_TIME_RST : 16'h0000;
        end
    end

    assign lock_off_out = lock_off_ff;
    assign frozen_out = frozen_ff;
    assign cmd_done_out = done_ff;
    assign status_out = status_ff;
    assign error_out = error_ff;
    assign id_word_out = id_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_frozen_reject;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (frozen_ff && cmd_in.valid && lock_cmd) |=> (cmd_done_out && error_out[`DSEF_ERR_ABT_BIT]);
    endproperty
    a_frozen_reject: assert property (p_frozen_reject) else $error("frozen lock cmd not aborted");

    property p_freeze_sets;
        @(posedge core_clk_in) disable iff (!por_nrst_in)
        (cmd_in.valid && cmd_in.opcode == `DSEF_OP_FREEZE) |=> frozen_out;
    endproperty
    a_freeze_sets: assert property (p_freeze_sets) else $error("freeze did not set");

    property p_frozen_stays;
        @(posedge core_clk_in) disable iff (!por_nrst_in)
        frozen_out |=> frozen_out;
    endproperty
    a_frozen_stays: assert property (p_frozen_stays) else $error("frozen cleared");

    property p_noprep_abort;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (cmd_in.valid && cmd_in.opcode == `DSEF_OP_ERASE && !prep_ff) |=>
            (state_ff == DSEF_IDLE && status_out[`DSEF_ST_ERR_BIT]);
    endproperty
    a_noprep_abort: assert property (p_noprep_abort) else $error("erase without prepare ran");

    property p_bad_pw;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_ff == DSEF_CHECK && sec_enabled_in && !pw_ok) |=> (state_ff == DSEF_DONE) ##1
            (error_out[`DSEF_ERR_ABT_BIT] && !media_wr_out.valid);
    endproperty
    a_bad_pw: assert property (p_bad_pw) else $error("bad password not aborted");

    property p_user_disabled;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_ff == DSEF_CHECK && !sec_enabled_in && id_user) |=> state_ff == DSEF_DONE;
    endproperty
    a_user_disabled: assert property (p_user_disabled) else $error("disabled user id not aborted");

    property p_no_compare;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_ff == DSEF_CHECK && !sec_enabled_in && !id_user) |=> media_wr_out.valid;
    endproperty
    a_no_compare: assert property (p_no_compare) else $error("disabled erase did not start");

    property p_erase_from_zero;
        @(posedge core_clk_in) disable iff (!nrst_in)
        $rose(media_wr_out.valid) |-> (media_wr_out.lba == '0 && media_wdata_out == 16'h0000);
    endproperty
    a_erase_from_zero: assert property (p_erase_from_zero) else $error("erase not from lba 0");

    property p_lock_after_wipe;
        @(posedge core_clk_in) disable iff (!nrst_in)
        lock_off_out |-> $past(media_wr_out.valid) && $past(media_wr_out.lba) == max_ff;
    endproperty
    a_lock_after_wipe: assert property (p_lock_after_wipe) else $error("lock off before wipe");

    property p_done_status;
        @(posedge core_clk_in) disable iff (!nrst_in)
        cmd_done_out |-> (!status_out[`DSEF_ST_BSY_BIT] && !status_out[`DSEF_ST_DF_BIT] &&
            (error_out & 8'heb) == 8'h00);
    endproperty
    a_done_status: assert property (p_done_status) else $error("bad completion status");

    property p_drq_after_accept;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_ff == DSEF_IDLE && nxt_state == DSEF_XFER) |-> ##2 status_out[`DSEF_ST_DRQ_BIT];
    endproperty
    a_drq_after_accept: assert property (p_drq_after_accept) else $error("no data request");

    property p_sector_count;
        @(posedge core_clk_in) disable iff (!nrst_in)
        $rose(state_ff == DSEF_CHECK) |-> ($past(wcnt_ff) == `DSEF_SECTOR_LAST_WORD);
    endproperty
    a_sector_count: assert property (p_sector_count) else $error("sector length wrong");

    property p_zero_data;
        @(posedge core_clk_in) disable iff (!nrst_in)
        media_wr_out.valid |-> (media_wdata_out == 16'h0000);
    endproperty
    a_zero_data: assert property (p_zero_data) else $error("wipe data not zero");

    property p_wipe_step;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (media_wr_out.valid && media_ready_in && (media_wr_out.lba != 48'(max_ff))) |=>
            (media_wr_out.lba == $past(media_wr_out.lba) + 48'h1);
    endproperty
    a_wipe_step: assert property (p_wipe_step) else $error("wipe skipped a block");

    property p_max_native;
        @(posedge core_clk_in) disable iff (!nrst_in)
        $rose(media_wr_out.valid) |-> (max_ff == native_max_lba_in);
    endproperty
    a_max_native: assert property (p_max_native) else $error("wipe end not native max");

    property p_abort_no_wipe;
        @(posedge core_clk_in) disable iff (!nrst_in)
        abort_ff |-> !media_wr_out.valid;
    endproperty
    a_abort_no_wipe: assert property (p_abort_no_wipe) else $error("aborted erase wrote");

    property p_abort_status;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_ff == DSEF_DONE && abort_ff) |=>
            (status_out[`DSEF_ST_ERR_BIT] && error_out[`DSEF_ERR_ABT_BIT] && cmd_done_out);
    endproperty
    a_abort_status: assert property (p_abort_status) else $error("abort not reported");

    property p_freeze_ok;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (cmd_in.valid && cmd_in.opcode == `DSEF_OP_FREEZE && state_ff == DSEF_IDLE) |=>
            (cmd_done_out && frozen_out && error_out == 8'h00);
    endproperty
    a_freeze_ok: assert property (p_freeze_ok) else $error("freeze not completed");

    property p_id_word;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (id_word_sel_in == `DSEF_ID_ERASE_TIME_WORD) |=> (id_word_out == `DSEF_ERASE_TIME_RST);
    endproperty
    a_id_word: assert property (p_id_word) else $error("erase time word wrong");

    property p_prep_needed;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_ff == DSEF_IDLE && nxt_state == DSEF_XFER) |-> (prep_ff && !frozen_ff);
    endproperty
    a_prep_needed: assert property (p_prep_needed) else $error("erase accepted wrongly");
endmodule : dsef_core

// ==== dsef_host.sv ====
/*
 Host controller model: issues task-file commands and one data sector.
 Assumes the caller runs its tasks from the bench's main sequence.
*/
`timescale 1ns/1ns
module dsef_host (
    input wire logic core_clk_in,
    output dsef_pkg::dsef_cmd_t cmd_out,
    output dsef_pkg::dsef_word_t word_out
);
    import dsef_pkg::*;
    initial begin
        cmd_out = '0;
        word_out = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One-cycle command register write
    task automatic issue(input logic [7:0] op);
        @(posedge core_clk_in);
        cmd_out <= '{opcode: op, valid: 1'b1};
        @(posedge core_clk_in);
        cmd_out <= '0;
    endtask : issue
    ////////////////////////////////////////////////////////////////////////////
    // Whole sector, one word a cycle; reserved words carry a changing pattern
    task automatic send_sector(input logic [15:0] ctrl, input logic [255:0] pw);
        logic [15:0] w;
        for (int i = 0; i < 256; i++) begin
            if (i == 0) w = ctrl;
            else if (i <= 16) w = pw[(i-1)*16 +: 16];
            else w = 16'ha5a5 ^ 16'(i);
            @(posedge core_clk_in);
            word_out <= '{data: w, valid: 1'b1};
        end
        @(posedge core_clk_in);
        word_out <= '0;
    endtask : send_sector
endmodule : dsef_host

// ==== test_drive_security_erase_freeze.sv ====
/*
 Self-checking bench for the security erase and freeze-lock block.
 Assumes the package, the constant header and the host model are compiled first.
*/
`timescale 1ns/1ns
`include "dsef_params.svh"
module test_drive_security_erase_freeze;
    import dsef_pkg::*;
    localparam logic [47:0] MAX_LBA = 48'h5;
    localparam logic [255:0] USER_PW = {8{32'h1357_2468}};
    localparam logic [255:0] MASTER_PW = {8{32'h9abc_def0}};
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic por_nrst_in = 1'b0;
    logic sec_enabled_in = 1'b1;
    logic media_ready_in = 1'b0;
    logic [7:0] id_word_sel_in = 8'h00;
    dsef_cmd_t cmd_in;
    dsef_word_t wdata_in;
    dsef_wr_t media_wr_out;
    logic [15:0] media_wdata_out;
    logic lock_off_out;
    logic frozen_out;
    logic cmd_done_out;
    logic [7:0] status_out;
    logic [7:0] error_out;
    logic [15:0] id_word_out;
    logic [47:0] exp_lba = 48'h0;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int lock_pulses = 0;
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 core_clk_in = ~core_clk_in;
    end
    dsef_host u_host (.core_clk_in(core_clk_in), .cmd_out(cmd_in), .word_out(wdata_in));
    dsef_core #(.LBA_W(48), .PW_WORDS(16)) u_dut (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .por_nrst_in(por_nrst_in),
        .cmd_in(cmd_in), .wdata_in(wdata_in), .native_max_lba_in(MAX_LBA),
        .user_pw_in(USER_PW), .master_pw_in(MASTER_PW), .sec_enabled_in(sec_enabled_in),
        .media_ready_in(media_ready_in), .id_word_sel_in(id_word_sel_in),
        .media_wr_out(media_wr_out), .media_wdata_out(media_wdata_out),
        .lock_off_out(lock_off_out), .frozen_out(frozen_out), .cmd_done_out(cmd_done_out),
        .status_out(status_out), .error_out(error_out), .id_word_out(id_word_out));
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wait_done(input int lim);
        for (int n = 0; n < lim; n++) begin
            #1;
            if (cmd_done_out === 1'b1) break;
            @(posedge core_clk_in);
        end
        chk(48'(cmd_done_out), 48'h1, "completion pulse");
    endtask : wait_done
    task automatic expect_abort(input logic [7:0] op);
        u_host.issue(op);
        wait_done(4);
        chk(48'(status_out), 48'h51, "abort status");
        chk(48'(error_out), 48'h04, "abort error");
    endtask : expect_abort
    ////////////////////////////////////////////////////////////////////////////
    // Wipe monitor and ready stalls, sampled at the edge the design sees
    always @(posedge core_clk_in) begin
        cyc++;
        media_ready_in <= (cyc % 4) != 0;
        if (media_wr_out.valid === 1'b1 && media_ready_in === 1'b1) begin
            chk(media_wr_out.lba, exp_lba, "wipe address");
            chk(48'(media_wdata_out), 48'h0, "wipe data");
            exp_lba = exp_lba + 48'h1;
        end
        if (lock_off_out === 1'b1) begin
            chk(exp_lba, MAX_LBA + 48'h1, "lock off before wipe end");
            lock_pulses++;
        end
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Prepare, erase, sector, then judge the outcome
    task automatic run_erase(input logic sec, input logic [15:0] ctrl, input logic [255:0] pw,
                             input logic ok);
        int locks0;
        @(posedge core_clk_in);
        sec_enabled_in <= sec;
        exp_lba = 48'h0;
        locks0 = lock_pulses;
        u_host.issue(`DSEF_OP_PREPARE);
        wait_done(4);
        u_host.issue(`DSEF_OP_ERASE);
        for (int n = 0; n < 4 && status_out !== 8'h58; n++) @(posedge core_clk_in) #1;
        chk(48'(status_out), 48'h58, "data request");
        u_host.send_sector(ctrl, pw);
        wait_done(300);
        chk(48'(lock_pulses - locks0), 48'(ok), "lock off pulse count");
        chk(48'(status_out), ok ? 48'h50 : 48'h51, "erase status");
        chk(48'(error_out), ok ? 48'h00 : 48'h04, "erase error");
        chk(exp_lba, ok ? MAX_LBA + 48'h1 : 48'h0, "wipe count");
    endtask : run_erase
    task automatic s_identify();
        @(posedge core_clk_in);
        id_word_sel_in <= 8'h59;
        @(posedge core_clk_in);
        id_word_sel_in <= 8'h58;
        #1;
        chk(48'(id_word_out), 48'h0001, "erase time word");
        @(posedge core_clk_in) #1;
        chk(48'(id_word_out), 48'h0, "other identify word");
    endtask : s_identify
    task automatic s_freeze();
        u_host.issue(`DSEF_OP_FREEZE);
        wait_done(4);
        chk(48'(frozen_out), 48'h1, "frozen");
        chk(48'(error_out), 48'h0, "freeze error");
        expect_abort(`DSEF_OP_SET_PW);
        expect_abort(`DSEF_OP_UNLOCK);
        expect_abort(`DSEF_OP_DISABLE);
        expect_abort(`DSEF_OP_ERASE);
        @(posedge core_clk_in);
        nrst_in <= 1'b0;
        @(posedge core_clk_in);
        nrst_in <= 1'b1;
        #1;
        chk(48'(frozen_out), 48'h1, "frozen through reset");
        chk(48'(status_out), 48'h50, "status after reset");
        @(posedge core_clk_in);
        por_nrst_in <= 1'b0;
        @(posedge core_clk_in);
        por_nrst_in <= 1'b1;
        #1;
        chk(48'(frozen_out), 48'h0, "frozen cleared at power on");
    endtask : s_freeze
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        por_nrst_in <= 1'b1;
        #1;
        chk(48'(status_out), 48'h50, "reset status");
        chk(48'(frozen_out), 48'h0, "reset frozen");
        s_identify();
        expect_abort(`DSEF_OP_ERASE);
        run_erase(1'b1, 16'h0000, USER_PW ^ 256'h1, 1'b0);
        run_erase(1'b1, 16'h0001, USER_PW, 1'b0);
        run_erase(1'b1, 16'h0001, MASTER_PW, 1'b1);
        run_erase(1'b1, 16'h0000, USER_PW, 1'b1);
        run_erase(1'b0, 16'h0000, USER_PW, 1'b0);
        run_erase(1'b0, 16'h0001, 256'h0, 1'b1);
        s_freeze();
        test_done();
    end
endmodule : test_drive_security_erase_freeze
